/* design/rar_consts.svh */
// Register offsets, field positions and reset values of the alarm and scratch registers
`ifndef RAR_CONSTS_SVH
`define RAR_CONSTS_SVH

`define RAR_ADDR_WEEK_MASK   4'hA
`define RAR_ADDR_DAY_MIN     4'hB
`define RAR_ADDR_DAY_HOUR    4'hC
`define RAR_ADDR_SCRATCH     4'hD
`define RAR_MASK_WEEK        8'h7F
`define RAR_MASK_MIN         8'h7F
`define RAR_MASK_HOUR        8'h3F
`define RAR_HOUR_BIT5        5
`define RAR_RESET_SCRATCH    8'h00
`define RAR_RESET_ALARM      8'h00
`define RAR_MIDNIGHT_12H     8'h12
`define RAR_NOON_12H         8'h32

`endif

/* design/rar_pkg.sv */
// Types shared by the alarm and scratch register block
package rar_pkg;

  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rar_wr_s;

  typedef struct packed {
    logic [2:0] weekday;
    logic [7:0] hour;
    logic [7:0] minute;
  } rar_time_s;

endpackage

/* design/rar_alarm_regs.sv */
// Alarm setting registers, user scratch byte and alarm match outputs
// How it works
// - Hour bit 5 is the p.m. flag in 12-hour mode, tens-high in 24-hour.
// - Daily alarm hour bit 5 stored as either p.m. flag or hour tens.
// - In 12-hour mode midnight is BCD 12, noon BCD 32, both alarms.
// - Day-mask bit n selects day-of-week counter code n, codes 000 to 110.
// - An all-zero day mask never gives a weekly match.
// - The scratch byte stores and returns any written pattern unchanged.
// - Power-on from zero volts clears the scratch byte; alarm fields unset (reset here loads zero into them).
`timescale 1ns/10ps
`include "rar_consts.svh"

module rar_alarm_regs (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  // Register access from the serial bus engine
  input  wire rar_pkg::rar_wr_s  wr_i,
  input  wire logic [3:0]        rd_addr_i,
  output logic [7:0]             rd_data_o,
  // Weekly alarm minute and hour held by neighbouring registers
  input  wire logic [7:0]        week_minute_i,
  input  wire logic [7:0]        week_hour_i,
  // Current time from the counters
  input  wire rar_pkg::rar_time_s now_i,
  // Match outputs
  output logic                   week_match_o,
  output logic                   day_match_o
);

  // ****************************************************
  // Assertion defaults
  // ****************************************************
  // One clock domain, so every property below shares this clock and
  // is switched off while the power-on reset is held.
  default clocking cb_main @(posedge mclk_i);
  endclocking

  default disable iff (!rst_n_i);

  // ****************************************************
  // Register state
  // ****************************************************
  logic [7:0] week_mask;
  logic [7:0] day_min;
  logic [7:0] day_hour;
  logic [7:0] scratch;
  logic [7:0] next_week_mask;
  logic [7:0] next_day_min;
  logic [7:0] next_day_hour;
  logic [7:0] next_scratch;
  logic       next_week_match;
  logic       next_day_match;
  logic [7:0] next_rd_data;

  always_comb begin
    next_week_mask = week_mask;
    next_day_min   = day_min;
    next_day_hour  = day_hour;
    next_scratch   = scratch;
    if (wr_i.wr) begin
      case (wr_i.addr)
        `RAR_ADDR_WEEK_MASK: next_week_mask = wr_i.wdata & `RAR_MASK_WEEK;
        `RAR_ADDR_DAY_MIN:   next_day_min   = wr_i.wdata & `RAR_MASK_MIN;
        `RAR_ADDR_DAY_HOUR:  next_day_hour  = wr_i.wdata & `RAR_MASK_HOUR;
        `RAR_ADDR_SCRATCH:   next_scratch   = wr_i.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************
  // Read mux and alarm compare
  // ****************************************************
  logic       week_day_hit;
  logic [6:0] day_hit_vec;

  // one decoder per day
  // Only seven mask bits exist, so the unused weekday code 111 has no
  // decoder and can never raise a weekly match.
  generate
    for (genvar n = 0; n < 7; n++) begin : g_day
      assign day_hit_vec[n] = week_mask[n]
                            && (now_i.weekday == 3'(n));
    end
  endgenerate

  always_comb begin
    case (rd_addr_i)
      `RAR_ADDR_WEEK_MASK: next_rd_data = week_mask;
      `RAR_ADDR_DAY_MIN:   next_rd_data = day_min;
      `RAR_ADDR_DAY_HOUR:  next_rd_data = day_hour;
      `RAR_ADDR_SCRATCH:   next_rd_data = scratch;
      default:             next_rd_data = 8'h00;
    endcase
    week_day_hit = |day_hit_vec;
    // hour bit 5 compared as stored, so mode meaning passes through
    // BCD 12 and 32 match counters that use the same encoding
    // weekly needs day, hour and minute
    next_week_match = week_day_hit
                    && (now_i.hour == (week_hour_i & `RAR_MASK_HOUR))
                    && (now_i.minute == (week_minute_i & `RAR_MASK_MIN));
    next_day_match  = (now_i.hour == day_hour)
                    && (now_i.minute == day_min);
  end

  // Alarm fields are undefined after power-on; zero is chosen so that
  // the weekly alarm stays silent until software arms it.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      week_mask <= `RAR_RESET_ALARM;
      day_min   <= `RAR_RESET_ALARM;
      day_hour  <= `RAR_RESET_ALARM;
      scratch   <= `RAR_RESET_SCRATCH;
    end else if (clk_en_i) begin
      week_mask <= next_week_mask;
      day_min   <= next_day_min;
      day_hour  <= next_day_hour;
      scratch   <= next_scratch;
    end
  end

  // Registered outputs cost one cycle of latency but give the bus
  // engine and the flag logic values that never glitch mid-cycle.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o    <= 8'h00;
      week_match_o <= 1'h0;
      day_match_o  <= 1'h0;
    end else if (clk_en_i) begin
      rd_data_o    <= next_rd_data;
      week_match_o <= next_week_match;
      day_match_o  <= next_day_match;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  // A scratch write, then a plain read of the same byte
  sequence s_scratch_write;
    clk_en_i && wr_i.wr && wr_i.addr == `RAR_ADDR_SCRATCH;
  endsequence

  sequence s_scratch_read;
    clk_en_i && !wr_i.wr && rd_addr_i == `RAR_ADDR_SCRATCH;
  endsequence

  // no weekly match when mask empty
  a_empty_mask_silent: assert property (
    clk_en_i && week_mask == 8'h00 |=> !week_match_o)
    else $error("weekly match with empty mask");

  a_high_bits_zero: assert property (
    clk_en_i && rd_addr_i == `RAR_ADDR_DAY_HOUR
    |=> rd_data_o[7:6] == 2'h0)
    else $error("hour high bits not zero");

  // mask and minute top bit zero
  a_top_bit_zero: assert property (
    clk_en_i && (rd_addr_i == `RAR_ADDR_WEEK_MASK
                 || rd_addr_i == `RAR_ADDR_DAY_MIN)
    |=> !rd_data_o[7])
    else $error("mask or minute top bit not zero");

  a_scratch_echo: assert property (
    s_scratch_write ##1 s_scratch_read
    |=> rd_data_o == $past(wr_i.wdata, 2))
    else $error("scratch readback mismatch");

  // scratch write leaves week_mask, day_min and day_hour unchanged
  a_scratch_isolated: assert property (
    s_scratch_write
    |=> $stable(week_mask) && $stable(day_min) && $stable(day_hour))
    else $error("scratch write changed an alarm field");

  a_day_match: assert property (
    clk_en_i && now_i.hour == day_hour && now_i.minute == day_min
    |=> day_match_o)
    else $error("daily match missed");

  a_day_disabled: assert property (
    clk_en_i && !week_mask[now_i.weekday] |=> !week_match_o)
    else $error("weekly match on disabled day");

  a_hour_bit5: assert property (
    clk_en_i && wr_i.wr && wr_i.addr == `RAR_ADDR_DAY_HOUR
    |=> day_hour[`RAR_HOUR_BIT5] == $past(wr_i.wdata[`RAR_HOUR_BIT5]))
    else $error("hour bit 5 lost");

  a_pm_bit_week: assert property (
    clk_en_i
    && now_i.hour[`RAR_HOUR_BIT5] != week_hour_i[`RAR_HOUR_BIT5]
    |=> !week_match_o)
    else $error("weekly match across a.m. and p.m.");

  a_noon_week: assert property (
    clk_en_i && week_mask[now_i.weekday] && week_hour_i == `RAR_NOON_12H
    && now_i.hour == `RAR_NOON_12H && now_i.minute == week_minute_i
    && !week_minute_i[7] |=> week_match_o)
    else $error("weekly noon not matched");

  a_midnight_day: assert property (
    clk_en_i && day_hour == `RAR_MIDNIGHT_12H && now_i.hour == day_hour
    && now_i.minute == day_min |=> day_match_o)
    else $error("daily midnight not matched");

endmodule // rar_alarm_regs

/* verification/rar_host_model.sv */
// Host model that issues register writes and reads
`timescale 1ns/10ps
module rar_host_model (
  // Clock
  input  wire logic        mclk_i,
  // Register access
  output rar_pkg::rar_wr_s wr_o,
  output logic [3:0]       rd_addr_o,
  output logic             rd_req_o
);
  initial begin
    wr_o = '0;
    rd_addr_o = 4'h0;
    rd_req_o = 1'b0;
  end
  task automatic op(input logic w, input logic [3:0] a,
                    input logic [7:0] d, input logic r);
    @(posedge mclk_i);
    // Idle data lines show a changed pattern, not the last byte
    wr_o <= '{wr: w, addr: a, wdata: w ? d : ~d};
    rd_addr_o <= a;
    rd_req_o <= r;
  endtask
endmodule // rar_host_model

/* verification/tb_rar_alarm_regs.sv */
// Self-checking bench for the alarm and scratch registers
`timescale 1ns/10ps
module tb_rar_alarm_regs;
  logic               mclk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic [7:0]         rd_data_o, wmin, whour, v;
  logic               week_match_o, day_match_o, rd_req, rd_pend;
  logic               clk_en = 1'b1;
  logic               mt_req = 1'b0;
  logic               mt_pend;
  logic [1:0]         mq[$];
  logic [1:0]         mexp;
  rar_pkg::rar_wr_s   wr;
  logic [3:0]         rd_addr;
  rar_pkg::rar_time_s now = '0;
  logic [7:0]         exp_q[$];
  int                 failures = 0, check_count = 0, seed = 32'hc6dc;
  always #4 mclk_i = ~mclk_i;
  rar_host_model u_rar_host_model (.mclk_i(mclk_i), .wr_o(wr),
    .rd_addr_o(rd_addr), .rd_req_o(rd_req));
  rar_alarm_regs u_rar_alarm_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en), .wr_i(wr), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data_o), .week_minute_i(wmin), .week_hour_i(whour),
    .now_i(now), .week_match_o(week_match_o), .day_match_o(day_match_o));
  task automatic cmp(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_match(input string n, input logic e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    u_rar_host_model.op(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_rar_host_model.op(1'b0, a, 8'h00, 1'b1);
  endtask
  task automatic mt(input logic [2:0] d, input logic [7:0] h, m,
                    input logic we, de);
    @(posedge mclk_i);
    now <= '{weekday: d, hour: h, minute: m};
    mt_req <= 1'b1;
    mq.push_back({we, de});
    @(posedge mclk_i);
    mt_req <= 1'b0;
  endtask
  always @(posedge mclk_i) rd_pend <= rd_req;
  // Read data is settled half a cycle after the edge that registers it
  always @(negedge mclk_i) if (rd_pend === 1'b1) begin
    if (exp_q.size() == 0) cmp("rd_queue", 8'h01, 8'h00);
    else cmp("rd_data", exp_q.pop_front(), rd_data_o);
  end
  always @(posedge mclk_i) mt_pend <= mt_req;
  // Match outputs are registered one edge after the time is presented
  always @(negedge mclk_i) if (mt_pend === 1'b1) begin
    if (mq.size() == 0) cmp_match("match_queue", 1'b1, 1'b0);
    else begin
      mexp = mq.pop_front();
      cmp_match("week_match", mexp[1], week_match_o);
      cmp_match("day_match", mexp[0], day_match_o);
    end
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    summarize();
  end
  initial begin
    wmin = 8'h00;
    whour = 8'h00;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(4'hD, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wr_reg(4'hD, v);
      rd(4'hD, v);
    end
    // A write while the clock enable is low must leave the byte alone
    wr_reg(4'hD, 8'h3C);
    clk_en <= 1'b0;
    u_rar_host_model.op(1'b0, 4'h0, 8'h00, 1'b0);
    clk_en <= 1'b1;
    rd(4'hD, v);
    wr_reg(4'hA, 8'hFF);
    wr_reg(4'hB, 8'hFF);
    wr_reg(4'hC, 8'hFF);
    rd(4'hA, 8'h7F);
    rd(4'hB, 8'h7F);
    rd(4'hC, 8'h3F);
    rd(4'hE, 8'h00);
    wr_reg(4'hB, 8'h30);
    wr_reg(4'hC, 8'h32);
    mt(3'd0, 8'h32, 8'h30, 1'b0, 1'b1);
    mt(3'd0, 8'h12, 8'h30, 1'b0, 1'b0);
    wr_reg(4'hC, 8'h12);
    mt(3'd0, 8'h12, 8'h30, 1'b0, 1'b1);
    @(posedge mclk_i);
    wmin <= 8'h30;
    whour <= 8'h12;
    for (int d = 0; d < 7; d++) begin
      wr_reg(4'hA, 8'h01 << d);
      mt(3'(d), 8'h12, 8'h30, 1'b1, 1'b1);
      mt(3'(d + 1), 8'h12, 8'h30, 1'b0, 1'b1);
    end
    @(posedge mclk_i);
    whour <= 8'h32;
    mt(3'd6, 8'h32, 8'h30, 1'b1, 1'b0);
    wr_reg(4'hA, 8'h00);
    mt(3'd0, 8'h12, 8'h30, 1'b0, 1'b1);
    // Mid-run power-on reset must clear a scratch byte holding data
    wr_reg(4'hD, 8'hA5);
    rd(4'hD, 8'hA5);
    u_rar_host_model.op(1'b0, 4'h0, 8'h00, 1'b0);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(4'hD, 8'h00);
    rd(4'hA, 8'h00);
    rd(4'hC, 8'h00);
    u_rar_host_model.op(1'b0, 4'h0, 8'h00, 1'b0);
    repeat (3) @(posedge mclk_i);
    summarize();
  end
endmodule // tb_rar_alarm_regs
